// ### measurement_sequencer_bench.sv
// self-checking bench of the measurement sequencer
`timescale 1ns/1ps
module measurement_sequencer_bench;
  logic CLK_SYS = 1'b0;
  logic RST_N = 1'b0;
  logic [5:0] AVS_ADDRESS = 6'h00;
  logic AVS_READ = 1'b0;
  logic AVS_WRITE = 1'b0;
  logic [31:0] AVS_WRITEDATA = 32'h0;
  logic [31:0] AVS_READDATA;
  logic AVS_WAITREQUEST;
  logic [15:0] ADC_DATA;
  logic [2:0] ADC_CHANNEL;
  logic ADC_ACTIVE;
  logic ALERT;
  logic [15:0] tv = 16'h0100;
  logic [15:0] sv = 16'h0064;
  logic [15:0] bv = 16'h0200;
  int errors = 0;
  int checks_done = 0;
  logic [2:0] pch = 3'h0;
  logic [2:0] seen = 3'h0;
  int rl = 0;
  int lr[3];
  int truns = 0;
  bit obad = 0;
  int n;
  logic [31:0] rd;
  logic [31:0] c1;
  logic [31:0] e1;

  always #20 CLK_SYS = ~CLK_SYS;

  // one microsecond per cycle keeps conversion periods short
  msq_sequencer #(.CYC_PER_US(1)) dut (
    .CLK_SYS(CLK_SYS),
    .RST_N(RST_N),
    .AVS_ADDRESS(AVS_ADDRESS),
    .AVS_READ(AVS_READ),
    .AVS_WRITE(AVS_WRITE),
    .AVS_WRITEDATA(AVS_WRITEDATA),
    .AVS_READDATA(AVS_READDATA),
    .AVS_WAITREQUEST(AVS_WAITREQUEST),
    .ADC_DATA(ADC_DATA),
    .ADC_CHANNEL(ADC_CHANNEL),
    .ADC_ACTIVE(ADC_ACTIVE),
    .ALERT(ALERT)
  );

  msq_adc_model adc (
    .clk(CLK_SYS),
    .chan(ADC_CHANNEL),
    .active(ADC_ACTIVE),
    .t_val(tv),
    .s_val(sv),
    .b_val(bv),
    .data(ADC_DATA)
  );

  // run length and order of channels on the converter
  always @(posedge CLK_SYS)
  begin
    if (ADC_CHANNEL != pch)
    begin
      if (pch == 3'h1 && ADC_CHANNEL != 3'h2)
        obad = 1;
      if (pch != 3'h0)
        lr[pch >> 1] = rl;
      if (ADC_CHANNEL == 3'h1)
        truns++;
      rl = 1;
    end
    else
      rl++;
    seen |= ADC_CHANNEL;
    pch = ADC_CHANNEL;
  end

  task automatic summarize;
    $display("errors %0d checks %0d", errors, checks_done);
    if (errors == 0 && checks_done > 0)
      $display("Simulation passed");
    else
      $display("Simulation failed");
    $finish;
  endtask : summarize

  task automatic chk(input string nm, input logic [31:0] e,
                     input logic [31:0] g);
    checks_done++;
    if (g !== e)
    begin
      errors++;
      $display("wrong value %s exp %h got %h", nm, e, g);
    end
  endtask : chk

  // waits for the edge that samples waitrequest low
  task automatic ack;
    int k;
    k = 0;
    @(posedge CLK_SYS);
    while (AVS_WAITREQUEST !== 1'b0 && k < 50)
    begin
      @(posedge CLK_SYS);
      k++;
    end
    if (k >= 50)
      chk("bus ack", 32'h0, 32'h1);
  endtask : ack

  task automatic wr(input logic [5:0] a, input logic [31:0] d);
    @(posedge CLK_SYS);
    AVS_ADDRESS <= a;
    AVS_WRITEDATA <= d;
    AVS_WRITE <= 1'b1;
    ack;
    AVS_WRITE <= 1'b0;
  endtask : wr

  task automatic rdr(input logic [5:0] a);
    @(posedge CLK_SYS);
    AVS_ADDRESS <= a;
    AVS_READ <= 1'b1;
    ack;
    rd = AVS_READDATA;
    AVS_READ <= 1'b0;
  endtask : rdr

  task automatic rchk(input string nm, input logic [5:0] a,
                      input logic [31:0] e);
    rdr(a);
    chk(nm, e, rd);
  endtask : rchk

  function automatic logic [31:0] mk(input logic [2:0] a, t, b, s, m);
    msq_pkg::msq_setup_type x;
    x = '{avg: a, ct_temp: t, ct_bus: b, ct_shunt: s, mode: m};
    return {17'h0, x};
  endfunction : mk

  // settle first, then wait for the sequence to stop
  task automatic idle;
    int k;
    k = 0;
    repeat (5) @(posedge CLK_SYS);
    while (ADC_ACTIVE !== 1'b0 && k < 20000)
    begin
      @(posedge CLK_SYS);
      k++;
    end
    // one more edge lets the channel monitor record the last run
    @(posedge CLK_SYS);
    chk("idle wait", 32'h1, 32'(k < 20000));
  endtask : idle

  task automatic until_ch(input logic [2:0] c, output int k);
    k = 0;
    while (ADC_CHANNEL !== c && k < 3000)
    begin
      @(posedge CLK_SYS);
      k++;
    end
  endtask : until_ch

  // the poll read that returns the flag set also clears it
  task automatic poll_done;
    int k;
    k = 0;
    rd = 32'h0;
    while (rd[msq_pkg::DIAG_DONE_BIT] !== 1'b1 && k < 500)
    begin
      rdr(msq_pkg::OFS_DIAG);
      k++;
    end
    chk("done poll", 32'h1, 32'(k < 500));
  endtask : poll_done

  initial
  begin
    repeat (60000) @(posedge CLK_SYS);
    errors++;
    summarize;
  end

  initial
  begin
    repeat (4) @(posedge CLK_SYS);
    RST_N <= 1'b1;
    rchk("setup rst", msq_pkg::OFS_SETUP, 32'h0b6d);
    rchk("config rst", msq_pkg::OFS_CONFIG, 32'h0);
    rchk("diag rst", msq_pkg::OFS_DIAG, 32'h0);
    rchk("unmapped", 6'h3c, 32'h0);
    chk("idle after rst", 32'h0, 32'(ADC_ACTIVE));
    // one triggered pass, three distinct periods
    obad = 0;
    seen = 3'h0;
    wr(msq_pkg::OFS_SETUP, mk(3'h0, 3'h2, 3'h0, 3'h1, msq_pkg::TRIG_ALL));
    idle;
    chk("temp period", 32'h96, 32'(lr[0]));
    chk("shunt period", 32'h54, 32'(lr[1]));
    chk("bus period", 32'h32, 32'(lr[2]));
    chk("all seen", 32'h7, 32'(seen));
    chk("temp first", 32'h0, 32'(obad));
    rchk("done set", msq_pkg::OFS_DIAG, 32'h1);
    rchk("done read clr", msq_pkg::OFS_DIAG, 32'h0);
    rchk("current", msq_pkg::OFS_CUR, 32'h60);
    rchk("bus", msq_pkg::OFS_BUS, 32'h200);
    rchk("temp", msq_pkg::OFS_TEMP, 32'h100);
    repeat (200) @(posedge CLK_SYS);
    chk("stays off", 32'h0, 32'(ADC_ACTIVE));
    wr(msq_pkg::OFS_SETUP, mk(3'h0, 3'h2, 3'h0, 3'h1, msq_pkg::TRIG_ALL));
    idle;
    rchk("power", msq_pkg::OFS_PWR, 32'hc000);
    // shutdown write keeps the flag, start write clears it
    wr(msq_pkg::OFS_SETUP, mk(3'h0, 3'h0, 3'h0, 3'h0, msq_pkg::MODE_OFF));
    wr(msq_pkg::OFS_DIAG, 32'h2);
    repeat (2) @(posedge CLK_SYS);
    chk("alert on", 32'h1, 32'(ALERT));
    seen = 3'h0;
    wr(msq_pkg::OFS_SETUP, mk(3'h0, 3'h0, 3'h0, 3'h0, msq_pkg::TRIG_CUR));
    repeat (2) @(posedge CLK_SYS);
    chk("alert clr", 32'h0, 32'(ALERT));
    rchk("diag clr", msq_pkg::OFS_DIAG, 32'h2);
    idle;
    chk("cur only", 32'h3, 32'(seen));
    chk("alert done", 32'h1, 32'(ALERT));
    rdr(msq_pkg::OFS_DIAG);
    repeat (2) @(posedge CLK_SYS);
    chk("alert read", 32'h0, 32'(ALERT));
    seen = 3'h0;
    wr(msq_pkg::OFS_SETUP, mk(3'h0, 3'h0, 3'h0, 3'h0, msq_pkg::TRIG_BUS));
    idle;
    chk("bus only", 32'h4, 32'(seen));
    wr(msq_pkg::OFS_DIAG, 32'h0);
    // four samples averaged, old result held meanwhile
    sv = 16'h00c8;
    truns = 0;
    wr(msq_pkg::OFS_SETUP, mk(3'h1, 3'h0, 3'h0, 3'h0, msq_pkg::TRIG_ALL));
    repeat (100) @(posedge CLK_SYS);
    rchk("cur held", msq_pkg::OFS_CUR, 32'h60);
    idle;
    chk("avg passes", 32'h4, 32'(truns));
    rchk("cur avg", msq_pkg::OFS_CUR, 32'hc4);
    rchk("temp avg", msq_pkg::OFS_TEMP, 32'h100);
    // mode write during shunt restarts from temperature
    wr(msq_pkg::OFS_SETUP, mk(3'h0, 3'h2, 3'h0, 3'h1, msq_pkg::CONT_ALL));
    until_ch(3'h2, n);
    wr(msq_pkg::OFS_SETUP, mk(3'h0, 3'h2, 3'h0, 3'h1, msq_pkg::CONT_ALL));
    until_ch(3'h1, n);
    chk("restart", 32'h1, 32'(n <= 4));
    // charge and energy step once per pass
    poll_done;
    rdr(msq_pkg::OFS_CHARGE);
    c1 = rd;
    rdr(msq_pkg::OFS_ENERGY);
    e1 = rd;
    poll_done;
    rdr(msq_pkg::OFS_CHARGE);
    chk("charge step", 32'hc4, rd - c1);
    rdr(msq_pkg::OFS_ENERGY);
    chk("energy step", 32'h18800, rd - e1);
    chk("cont runs", 32'h1, 32'(ADC_ACTIVE));
    // stop first so the channel reads zero while the delay runs
    wr(msq_pkg::OFS_SETUP, mk(3'h0, 3'h0, 3'h0, 3'h0, msq_pkg::MODE_OFF));
    idle;
    // one step of start delay before the first period
    wr(msq_pkg::OFS_CONFIG, 32'h1);
    wr(msq_pkg::OFS_SETUP, mk(3'h0, 3'h0, 3'h0, 3'h0, msq_pkg::TRIG_ALL));
    until_ch(3'h1, n);
    chk("delay", 32'h1, 32'(n >= 2000 && n <= 2004));
    idle;
    wr(msq_pkg::OFS_CONFIG, 32'h0);
    summarize;
  end
endmodule : measurement_sequencer_bench

// ### msq_adc_model.sv
// behavioural converter front end facing the sequencer
`timescale 1ns/1ps
module msq_adc_model (
  // clock
  input wire logic clk,
  // sequencer side
  input wire logic [2:0] chan,
  input wire logic active,
  // level of each input
  input wire logic [15:0] t_val,
  input wire logic [15:0] s_val,
  input wire logic [15:0] b_val,
  // sample out
  output logic [15:0] data
);
  logic [15:0] junk_q = 16'h5aa5;
  // idle output toggles so a stale sample never looks valid
  always @(posedge clk)
    junk_q <= ~junk_q;
  // one input on the converter at a time
  always_comb
  begin
    data = junk_q;
    if (active)
    begin
      case (chan)
        3'h1: data = t_val;
        3'h2: data = s_val;
        3'h4: data = b_val;
        default: data = junk_q;
      endcase
    end
  end
endmodule : msq_adc_model

// ### msq_pkg.sv
// constants, types and helpers of the measurement sequencer
// Overview of operation
// R01 - power uses prior current and newest bus
// R02 - averaging one loads results directly
// R03 - accumulate samples, load outputs at count
// R04 - energy and charge per pass, unaveraged
// R05 - calculations add no conversion time
// R06 - temperature converts before shunt, corrects current
// R07 - mode selects all, current only, bus only
// R08 - per-input conversion time 50 us to 4.12 ms
// R09 - current ready after temperature plus shunt
// R10 - inputs converted one at a time
// R11 - sequence repeats until averages gathered
// R12 - outputs hold until next complete result
// R13 - continuous mode loops until mode changes
// R14 - triggered mode runs one pass, then shutdown
// R15 - mode write aborts and restarts conversion
// R16 - done flag set after full pass averaging
// R17 - done flag cleared by setup write, diag read; a setup write of a shutdown mode leaves it set
// R18 - triggered mode energy and charge invalid
// R19 - start delay 0 to 510 ms, 2 ms steps
// R20 - filter settles within one conversion period
// R21 - averaging 1 to 1024, all inputs alike
// R22 - shutdown trigger completes then returns to shutdown
// R23 - ready alert gated, done flag always records
// R24 - start delay timed from starting write
package msq_pkg;
  localparam logic [5:0] OFS_CONFIG = 6'h00;
  localparam logic [5:0] OFS_SETUP = 6'h04;
  localparam logic [5:0] OFS_DIAG = 6'h08;
  localparam logic [5:0] OFS_CUR = 6'h0c;
  localparam logic [5:0] OFS_BUS = 6'h10;
  localparam logic [5:0] OFS_TEMP = 6'h14;
  localparam logic [5:0] OFS_PWR = 6'h18;
  localparam logic [5:0] OFS_ENERGY = 6'h1c;
  localparam logic [5:0] OFS_CHARGE = 6'h20;
  localparam int DIAG_DONE_BIT = 0;
  localparam int DIAG_RDYEN_BIT = 1;
  localparam int DLY_W = 8;
  localparam int SETUP_W = 15;
  localparam logic [SETUP_W-1:0] SETUP_RST = 15'h0b6d;
  localparam logic [DLY_W-1:0] DLY_RST = 8'h00;
  localparam int DELAY_STEP_US = 2000;
  localparam int TC_SHIFT = 6;
  localparam int CLK_MHZ = 25;
  typedef enum logic [2:0] {
    MODE_OFF = 3'h0, TRIG_ALL = 3'h1, TRIG_CUR = 3'h2, TRIG_BUS = 3'h3,
    CONT_ALL = 3'h5, CONT_CUR = 3'h6, CONT_BUS = 3'h7
  } msq_mode_type;
  typedef struct packed {
    logic [2:0] avg;
    logic [2:0] ct_temp;
    logic [2:0] ct_bus;
    logic [2:0] ct_shunt;
    logic [2:0] mode;
  } msq_setup_type;
  typedef enum logic [2:0] {
    CH_TEMP = 3'h1, CH_SHUNT = 3'h2, CH_BUS = 3'h4
  } msq_chan_type;
  typedef enum logic [2:0] {
    ST_IDLE = 3'h1, ST_DELAY = 3'h2, ST_CONV = 3'h4
  } msq_state_type;
  function automatic int ct_us(input logic [2:0] c);
    case (c)
      3'h0: return 50;
      3'h1: return 84;
      3'h2: return 150;
      3'h3: return 280;
      3'h4: return 540;
      3'h5: return 1052;
      3'h6: return 2074;
      default: return 4120;
    endcase
  endfunction : ct_us
  function automatic logic [3:0] avg_shift(input logic [2:0] c);
    case (c)
      3'h0: return 4'h0;
      3'h1: return 4'h2;
      3'h2: return 4'h4;
      3'h3: return 4'h6;
      3'h4: return 4'h7;
      3'h5: return 4'h8;
      3'h6: return 4'h9;
      default: return 4'ha;
    endcase
  endfunction : avg_shift
endpackage : msq_pkg

// ### msq_sequencer.sv
// measurement sequencer with averaging, power, energy and charge
`timescale 1ns/1ps
module msq_sequencer #(
  parameter int CYC_PER_US = msq_pkg::CLK_MHZ
) (
  // clock and reset
  input wire logic CLK_SYS,
  input wire logic RST_N,
  // avalon-mm slave
  input wire logic [5:0] AVS_ADDRESS,
  input wire logic AVS_READ,
  input wire logic AVS_WRITE,
  input wire logic [31:0] AVS_WRITEDATA,
  output logic [31:0] AVS_READDATA,
  output logic AVS_WAITREQUEST,
  // converter front end
  input wire logic [15:0] ADC_DATA,
  output logic [2:0] ADC_CHANNEL,
  output logic ADC_ACTIVE,
  // ready alert
  output logic ALERT
);
  generate
    if (CYC_PER_US < 1 || CYC_PER_US > 1000)
    begin : g_bad
      $error("CYC_PER_US out of range");
    end
  endgenerate

  localparam int DLY_CYC = msq_pkg::DELAY_STEP_US * CYC_PER_US;

  msq_pkg::msq_setup_type setup_q;
  msq_pkg::msq_state_type st_q;
  msq_pkg::msq_chan_type ch_q;
  msq_pkg::msq_chan_type ch_first;
  msq_pkg::msq_chan_type ch_next;
  localparam int DLY_W_L = msq_pkg::DLY_W;
  logic [DLY_W_L-1:0] dly_q;
  logic [31:0] timer_q;
  logic [9:0] avg_cnt_q;
  logic rdyen_q;
  logic rdyen_d;
  logic done_q;
  logic done_d;
  logic ack;
  logic wr_acc;
  logic rd_acc;
  logic setup_wr;
  logic diag_rd;
  logic mode_on;
  logic new_on;
  logic cont;
  logic cur_only;
  logic conv_end;
  logic pass_end;
  logic avg_done;
  logic [3:0] sh;
  logic [9:0] avg_last;
  logic [2:0] ct_code;
  logic signed [15:0] temp_s_q;
  logic signed [15:0] cur_inst_q;
  logic signed [15:0] cur_now;
  logic signed [25:0] acc_i_q;
  logic signed [25:0] acc_b_q;
  logic signed [25:0] acc_t_q;
  logic signed [25:0] acc_i_d;
  logic signed [25:0] acc_b_d;
  logic signed [25:0] acc_t_d;
  logic signed [15:0] cur_pass;
  logic signed [15:0] cur_q;
  logic signed [15:0] bus_q;
  logic signed [15:0] temp_q;
  logic signed [31:0] pwr_q;
  logic signed [31:0] energy_q;
  logic signed [31:0] charge_q;
  logic signed [15:0] avg_i;
  logic signed [15:0] avg_b;
  logic signed [15:0] avg_t;
  logic [31:0] rdata;

  // one wait state: request seen, then waitrequest low for one cycle
  assign ack = (AVS_READ || AVS_WRITE) && AVS_WAITREQUEST;
  assign wr_acc = AVS_WRITE && !AVS_WAITREQUEST;
  assign rd_acc = AVS_READ && !AVS_WAITREQUEST;
  assign setup_wr = wr_acc && AVS_ADDRESS == msq_pkg::OFS_SETUP;
  assign diag_rd = rd_acc && AVS_ADDRESS == msq_pkg::OFS_DIAG;
  assign new_on = AVS_WRITEDATA[2:0] != 3'h0
    && AVS_WRITEDATA[2:0] != 3'h4;
  assign mode_on = setup_q.mode != 3'h0 && setup_q.mode != 3'h4;
  assign cont = setup_q.mode[2];
  assign cur_only = setup_q.mode[1:0] == 2'h2;

  always_ff @(posedge CLK_SYS or negedge RST_N)
  begin
    if (!RST_N)
    begin
      AVS_WAITREQUEST <= 1'b1;
      AVS_READDATA <= 32'h0;
    end
    else
    begin
      AVS_WAITREQUEST <= !ack;
      if (ack)
      begin
        AVS_READDATA <= rdata;
      end
    end
  end

  // unmapped addresses read zero and ignore writes
  always_comb
  begin
    rdata = 32'h0;
    case (AVS_ADDRESS)
      msq_pkg::OFS_CONFIG: rdata = {24'h0, dly_q};
      msq_pkg::OFS_SETUP: rdata = {17'h0, setup_q};
      msq_pkg::OFS_DIAG:
      begin
        rdata[msq_pkg::DIAG_DONE_BIT] = done_q;
        rdata[msq_pkg::DIAG_RDYEN_BIT] = rdyen_q;
      end
      msq_pkg::OFS_CUR: rdata = 32'(cur_q);
      msq_pkg::OFS_BUS: rdata = 32'(bus_q);
      msq_pkg::OFS_TEMP: rdata = 32'(temp_q);
      msq_pkg::OFS_PWR: rdata = pwr_q;
      msq_pkg::OFS_ENERGY: rdata = energy_q;
      msq_pkg::OFS_CHARGE: rdata = charge_q;
      default: rdata = 32'h0;
    endcase
  end

  always_ff @(posedge CLK_SYS or negedge RST_N)
  begin
    if (!RST_N)
    begin
      setup_q <= msq_pkg::SETUP_RST;
      dly_q <= msq_pkg::DLY_RST; // [R19]
      rdyen_q <= 1'b0;
    end
    else if (wr_acc)
    begin
      if (AVS_ADDRESS == msq_pkg::OFS_SETUP)
      begin
        setup_q <= AVS_WRITEDATA[msq_pkg::SETUP_W-1:0]; // [R07] [R08] [R21]
      end
      if (AVS_ADDRESS == msq_pkg::OFS_CONFIG)
      begin
        dly_q <= AVS_WRITEDATA[DLY_W_L-1:0];
      end
      if (AVS_ADDRESS == msq_pkg::OFS_DIAG)
      begin
        rdyen_q <= AVS_WRITEDATA[msq_pkg::DIAG_RDYEN_BIT];
      end
    end
  end

  // channel order: temperature always directly before shunt
  always_comb
  begin
    ch_first = setup_q.mode[1:0] == 2'h3 ? msq_pkg::CH_BUS
      : msq_pkg::CH_TEMP; // [R06] [R07]
    ch_next = msq_pkg::CH_BUS;
    unique case (ch_q)
      msq_pkg::CH_TEMP: ch_next = msq_pkg::CH_SHUNT;
      msq_pkg::CH_SHUNT: ch_next = msq_pkg::CH_BUS;
      msq_pkg::CH_BUS: ch_next = msq_pkg::CH_TEMP;
    endcase
  end

  assign conv_end = st_q == msq_pkg::ST_CONV && timer_q == 32'h0;
  assign pass_end = conv_end && (ch_q == msq_pkg::CH_BUS
    || (cur_only && ch_q == msq_pkg::CH_SHUNT));
  assign sh = msq_pkg::avg_shift(setup_q.avg);
  assign avg_last = 10'((11'h1 << sh) - 11'h1);
  assign avg_done = pass_end && avg_cnt_q == avg_last; // [R11] [R21]

  // conversion time of the channel about to start
  always_comb
  begin
    ct_code = setup_q.ct_bus;
    if (st_q != msq_pkg::ST_CONV)
    begin
      ct_code = ch_first == msq_pkg::CH_BUS ? setup_q.ct_bus
        : setup_q.ct_temp;
    end
    else if (pass_end)
    begin
      ct_code = ch_first == msq_pkg::CH_BUS ? setup_q.ct_bus
        : setup_q.ct_temp;
    end
    else
    begin
      unique case (ch_next)
        msq_pkg::CH_TEMP: ct_code = setup_q.ct_temp;
        msq_pkg::CH_SHUNT: ct_code = setup_q.ct_shunt;
        msq_pkg::CH_BUS: ct_code = setup_q.ct_bus;
      endcase
    end
  end

  // sequencing fsm; every period is exactly the programmed time
  always_ff @(posedge CLK_SYS or negedge RST_N)
  begin
    if (!RST_N)
    begin
      st_q <= msq_pkg::ST_IDLE;
      ch_q <= msq_pkg::CH_TEMP;
      timer_q <= 32'h0;
      avg_cnt_q <= 10'h0;
    end
    else if (setup_wr)
    begin
      avg_cnt_q <= 10'h0; // [R15]
      ch_q <= msq_pkg::CH_TEMP;
      timer_q <= 32'(dly_q) * 32'(DLY_CYC); // [R24]
      st_q <= new_on ? msq_pkg::ST_DELAY : msq_pkg::ST_IDLE; // [R15]
    end
    else
    begin
      unique case (st_q)
        msq_pkg::ST_IDLE:
        begin
          timer_q <= 32'h0;
        end
        msq_pkg::ST_DELAY:
        begin
          if (timer_q != 32'h0)
          begin
            timer_q <= timer_q - 32'h1; // [R19]
          end
          else if (mode_on)
          begin
            st_q <= msq_pkg::ST_CONV;
            ch_q <= ch_first;
            timer_q <= 32'(msq_pkg::ct_us(ct_code) * CYC_PER_US - 1);
          end
          else
          begin
            st_q <= msq_pkg::ST_IDLE;
          end
        end
        msq_pkg::ST_CONV:
        begin
          if (!conv_end)
          begin
            timer_q <= timer_q - 32'h1; // [R08] [R20]
          end
          else if (!pass_end)
          begin
            ch_q <= ch_next; // [R10] [R09]
            timer_q <= 32'(msq_pkg::ct_us(ct_code) * CYC_PER_US - 1);
          end
          else if (avg_done && !cont)
          begin
            st_q <= msq_pkg::ST_IDLE; // [R14] [R22]
            avg_cnt_q <= 10'h0;
          end
          else
          begin
            ch_q <= ch_first; // [R13] [R11]
            avg_cnt_q <= avg_done ? 10'h0 : avg_cnt_q + 10'h1;
            timer_q <= 32'(msq_pkg::ct_us(ct_code) * CYC_PER_US - 1);
          end
        end
      endcase
    end
  end

  // temperature-corrected current from the latest die temperature
  assign cur_now = 16'($signed(ADC_DATA)
    - (temp_s_q >>> msq_pkg::TC_SHIFT)); // [R06]
  assign cur_pass = ch_q == msq_pkg::CH_SHUNT ? cur_now : cur_inst_q;

  // next sums hold this cycle's sample, so the last one of a run counts
  always_comb
  begin
    acc_i_d = acc_i_q;
    acc_b_d = acc_b_q;
    acc_t_d = acc_t_q;
    if (conv_end)
    begin
      unique case (ch_q)
        msq_pkg::CH_TEMP:
        begin
          acc_t_d = acc_t_q + 26'($signed(ADC_DATA)); // [R03]
        end
        msq_pkg::CH_SHUNT:
        begin
          acc_i_d = acc_i_q + 26'(cur_now); // [R03]
        end
        msq_pkg::CH_BUS:
        begin
          acc_b_d = acc_b_q + 26'($signed(ADC_DATA)); // [R03]
        end
      endcase
    end
  end
  assign avg_i = 16'(acc_i_d >>> sh);
  assign avg_b = 16'(acc_b_d >>> sh);
  assign avg_t = 16'(acc_t_d >>> sh);

  // latest samples kept apart from the sums, which clear per run
  always_ff @(posedge CLK_SYS or negedge RST_N)
  begin
    if (!RST_N)
    begin
      temp_s_q <= 16'sh0;
      cur_inst_q <= 16'sh0;
    end
    else if (conv_end && ch_q == msq_pkg::CH_TEMP)
    begin
      temp_s_q <= $signed(ADC_DATA); // [R06]
    end
    else if (conv_end && ch_q == msq_pkg::CH_SHUNT)
    begin
      cur_inst_q <= cur_now;
    end
  end

  always_ff @(posedge CLK_SYS or negedge RST_N)
  begin
    if (!RST_N)
    begin
      acc_i_q <= 26'sh0;
      acc_b_q <= 26'sh0;
      acc_t_q <= 26'sh0;
    end
    else if (setup_wr || avg_done)
    begin
      acc_i_q <= 26'sh0;
      acc_b_q <= 26'sh0;
      acc_t_q <= 26'sh0;
    end
    else
    begin
      acc_i_q <= acc_i_d; // [R03]
      acc_b_q <= acc_b_d;
      acc_t_q <= acc_t_d;
    end
  end

  // output registers change only on a completed result
  always_ff @(posedge CLK_SYS or negedge RST_N)
  begin
    if (!RST_N)
    begin
      cur_q <= 16'sh0;
      bus_q <= 16'sh0;
      temp_q <= 16'sh0;
      pwr_q <= 32'sh0;
    end
    else if (conv_end && sh == 4'h0)
    begin
      unique case (ch_q)
        msq_pkg::CH_TEMP: temp_q <= $signed(ADC_DATA); // [R02]
        msq_pkg::CH_SHUNT: cur_q <= cur_now; // [R02] [R09]
        msq_pkg::CH_BUS:
        begin
          bus_q <= $signed(ADC_DATA); // [R02]
          pwr_q <= cur_q * $signed(ADC_DATA); // [R01] [R05]
        end
      endcase
    end
    else if (avg_done)
    begin
      if (ch_first == msq_pkg::CH_TEMP)
      begin
        cur_q <= avg_i; // [R03] [R12]
        temp_q <= avg_t;
      end
      if (!cur_only)
      begin
        bus_q <= avg_b;
        pwr_q <= avg_i * avg_b; // [R01] [R03]
      end
    end
  end

  // energy counts each pass except in current-only mode, charge each pass except in bus-only mode; meaningless in triggered use
  always_ff @(posedge CLK_SYS or negedge RST_N)
  begin
    if (!RST_N)
    begin
      energy_q <= 32'sh0;
      charge_q <= 32'sh0;
    end
    else if (pass_end)
    begin
      if (!cur_only)
      begin
        energy_q <= energy_q
          + cur_inst_q * $signed(ADC_DATA); // [R04] [R01] [R18]
      end
      if (ch_first == msq_pkg::CH_TEMP)
      begin
        charge_q <= charge_q + 32'(cur_pass); // [R04] [R18]
      end
    end
  end

  // set wins over clear when both land on one edge; a read clears only
  // a flag it returned, so a set at the capture edge is not lost
  assign done_d = avg_done
    || (done_q && !(setup_wr && new_on)
    && !(diag_rd && AVS_READDATA[msq_pkg::DIAG_DONE_BIT])); // [R16] [R17]

  // enable change reaches the pin together with the stored bit
  assign rdyen_d = wr_acc && AVS_ADDRESS == msq_pkg::OFS_DIAG
    ? AVS_WRITEDATA[msq_pkg::DIAG_RDYEN_BIT] : rdyen_q;

  always_ff @(posedge CLK_SYS or negedge RST_N)
  begin
    if (!RST_N)
    begin
      done_q <= 1'b0;
      ALERT <= 1'b0;
      ADC_CHANNEL <= 3'h0;
      ADC_ACTIVE <= 1'b0;
    end
    else
    begin
      done_q <= done_d;
      ALERT <= done_d && rdyen_d; // [R23]
      // zero outside conversions so an idle channel is never mistaken
      ADC_CHANNEL <= st_q == msq_pkg::ST_CONV ? ch_q : 3'h0;
      ADC_ACTIVE <= st_q == msq_pkg::ST_CONV;
    end
  end

  default clocking cb @(posedge CLK_SYS);
  endclocking
  default disable iff (!RST_N);

  done_cause_a: assert property ($rose(done_q) |-> $past(avg_done)) // [R16]
    else $error("done flag set without a finished pass");
  done_clear_a: assert property (
    setup_wr && new_on && !avg_done |=> !done_q) // [R17]
    else $error("done flag not cleared by setup write");
  trig_stop_a: assert property (
    avg_done && !cont && !setup_wr |=> st_q == msq_pkg::ST_IDLE) // [R14]
    else $error("triggered pass did not return to shutdown");
  cont_loop_a: assert property (avg_done && cont && !setup_wr
    |=> st_q == msq_pkg::ST_CONV && ch_q == $past(ch_first)) // [R13]
    else $error("continuous mode did not restart sequence");
  mode_abort_a: assert property (
    setup_wr && new_on |=> st_q == msq_pkg::ST_DELAY) // [R15]
    else $error("mode write did not restart conversion");
  out_hold_a: assert property (!conv_end && !setup_wr
    |=> $stable(cur_q) && $stable(pwr_q) && $stable(bus_q)) // [R12]
    else $error("output changed without a completed result");
  temp_first_a: assert property (conv_end && !pass_end
    && ch_q == msq_pkg::CH_TEMP |=> ch_q == msq_pkg::CH_SHUNT) // [R06]
    else $error("shunt did not follow temperature");
  delay_count_a: assert property (st_q == msq_pkg::ST_DELAY // [R19]
    && timer_q != 32'h0 && !setup_wr |=> timer_q == $past(timer_q) - 1)
    else $error("start delay not counting down");
  energy_pass_a: assert property (!pass_end
    |=> $stable(energy_q) && $stable(charge_q)) // [R04]
    else $error("energy changed outside a pass end");
  alert_gate_a: assert property (ALERT |-> done_q && rdyen_q) // [R23]
    else $error("alert without enabled done flag");

  trig_pass_c: cover property (avg_done && !cont ##1 st_q == msq_pkg::ST_IDLE);
  cont_pass_c: cover property (avg_done && cont);
  avg_pass_c: cover property (avg_done && sh != 4'h0);
  delay_c: cover property (st_q == msq_pkg::ST_DELAY && timer_q > 32'h1);
endmodule : msq_sequencer
